// >>> shared/muxbus_pkg.sv
package muxbus_pkg;
  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int E_PERIOD_NS = 400;
  localparam int E_PHASES = E_PERIOD_NS / CLK_PERIOD_NS;
  localparam logic [1:0] PH_ADDR = 2'h0;
  localparam logic [1:0] PH_GAP = 2'h1;
  localparam logic [1:0] PH_LAST = 2'(E_PHASES - 1);
  localparam logic [1:0] BOOT_CYCLES = 2'h2;
  // ==========================================================
  // Modes
  localparam logic [2:0] MODE_TEST = 3'h0;
  localparam logic [2:0] MODE_FIXED_MAX = 3'h3;
  localparam logic [2:0] MODE_SELECT = 3'h6;
  // ==========================================================
  // Registers
  localparam int AXI_ADDR_W = 4;
  localparam logic [3:0] OFS_STATUS = 4'h0;
  localparam logic [3:0] OFS_UPPER_DIR = 4'h4;
  localparam logic [3:0] OFS_UPPER_IN = 4'h8;
  localparam logic [7:0] UPPER_DIR_RESET = 8'h00;
  localparam int ST_MODE_LSB = 0;
  localparam int ST_BOOT_BIT = 3;
  localparam int ST_EXP_BIT = 4;
  localparam logic [15:0] IDLE_ADDR = 16'hffff;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// >>> design/muxed_expansion_bus_port.sv
`timescale 1ns/100ps
`default_nettype none
module muxed_expansion_bus_port
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [2:0] mode_straps,
  input wire logic [15:0] cpu_addr,
  input wire logic cpu_rw,
  input wire logic cpu_idle,
  input wire logic cpu_internal,
  input wire logic [7:0] cpu_wdata,
  input wire logic [7:0] peripheral_bus,
  output logic cpu_take,
  output logic [7:0] cpu_rdata,
  output logic cpu_rdata_valid,
  output logic e_clk,
  output logic addr_strobe,
  output logic direction_pin,
  output logic [7:0] mux_out,
  output logic [7:0] mux_oe,
  input wire logic [7:0] mux_in,
  output logic [7:0] upper_out,
  output logic [7:0] upper_oe,
  input wire logic [7:0] upper_in,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // ==========================================================
  // Mode and phase
  logic [2:0] mode_q;
  logic [1:0] phase_q;
  logic [1:0] phase_d;
  logic mode_test;
  logic mode_fixed;
  logic mode_sel;
  logic expanded;

  // Strap follows the pins while reset is low, frozen after
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      mode_q <= mode_straps;
  end

  assign mode_test = (mode_q == muxbus_pkg::MODE_TEST);
  assign mode_fixed = (mode_q <= muxbus_pkg::MODE_FIXED_MAX);
  assign mode_sel = (mode_q == muxbus_pkg::MODE_SELECT);
  assign expanded = mode_fixed || mode_sel;

  // Reset parks on the last phase so the first edge opens a cycle
  assign phase_d = (phase_q == muxbus_pkg::PH_LAST) ? muxbus_pkg::PH_ADDR : phase_q + 2'h1;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      phase_q <= muxbus_pkg::PH_LAST;
    else
      phase_q <= phase_d;
  end

  assign cpu_take = aresetn && (phase_q == muxbus_pkg::PH_LAST);

  // ==========================================================
  // Cycle latch
  logic [15:0] cyc_addr_q;
  logic cyc_rw_q;
  logic cyc_idle_q;
  logic cyc_int_q;
  logic [7:0] cyc_wdata_q;
  logic cyc_boot_q;
  logic [1:0] boot_cnt_q;
  logic [15:0] n_addr;
  logic n_rw;
  logic n_int;
  logic n_boot;
  logic [7:0] n_wdata;
  logic n_drive_e;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cyc_addr_q <= muxbus_pkg::IDLE_ADDR;
      cyc_rw_q <= 1'b1;
      cyc_idle_q <= 1'b1;
      cyc_int_q <= 1'b0;
      cyc_wdata_q <= 8'h00;
      cyc_boot_q <= 1'b0;
      boot_cnt_q <= muxbus_pkg::BOOT_CYCLES;
    end
    else if (cpu_take)
    begin
      cyc_addr_q <= n_addr;
      cyc_rw_q <= n_rw;
      cyc_idle_q <= cpu_idle;
      cyc_int_q <= n_int;
      cyc_wdata_q <= n_wdata;
      cyc_boot_q <= n_boot;
      if (boot_cnt_q != 2'h0)
        boot_cnt_q <= boot_cnt_q - 2'h1;
    end
  end

  // Idle cycles look like a read of the top address
  assign n_addr = !cpu_take ? cyc_addr_q : (cpu_idle ? muxbus_pkg::IDLE_ADDR : cpu_addr);
  assign n_rw = !cpu_take ? cyc_rw_q : (cpu_idle || cpu_rw);
  assign n_int = !cpu_take ? cyc_int_q : (cpu_internal && !cpu_idle);
  assign n_wdata = !cpu_take ? cyc_wdata_q : cpu_wdata;
  assign n_boot = !cpu_take ? cyc_boot_q : (mode_test && boot_cnt_q != 2'h0);

  // Drive control for E: write, or mode 0 internal read after boot
  assign n_drive_e = !n_rw || (mode_test && n_int && !n_boot);

  // ==========================================================
  // Pins
  // All pins register the state of the phase being entered, so
  // the strobe, float and drive windows never overlap.
  logic entering_e;
  assign entering_e = phase_d[1];

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      e_clk <= 1'b0;
      addr_strobe <= 1'b1;
      direction_pin <= 1'b1;
      mux_oe <= 8'h00;
      mux_out <= 8'h00;
    end
    else if (!expanded)
    begin
      e_clk <= entering_e;
      addr_strobe <= 1'b0;
      direction_pin <= 1'b1;
      mux_oe <= 8'h00;
      mux_out <= 8'h00;
    end
    else
    begin
      e_clk <= entering_e;
      addr_strobe <= (phase_d == muxbus_pkg::PH_ADDR);
      direction_pin <= n_rw;
      if (phase_d == muxbus_pkg::PH_ADDR)
      begin
        mux_oe <= 8'hff;
        mux_out <= n_addr[7:0];
      end
      else if (entering_e && n_drive_e)
      begin
        mux_oe <= 8'hff;
        mux_out <= !n_rw ? n_wdata : peripheral_bus;
      end
      else
      begin
        mux_oe <= 8'h00;
        mux_out <= 8'h00;
      end
    end
  end

  // Upper port has no output register of its own in these modes
  logic [7:0] upper_dir_q;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      upper_out <= 8'hff;
      upper_oe <= (mode_straps <= muxbus_pkg::MODE_FIXED_MAX) ? 8'hff : 8'h00;
    end
    else
    begin
      upper_out <= n_addr[15:8];
      if (mode_fixed)
        upper_oe <= 8'hff;
      else if (mode_sel)
        upper_oe <= upper_dir_q;
      else
        upper_oe <= 8'h00;
    end
  end

  // ==========================================================
  // Read path
  logic internal_read_couple;
  logic external_read_couple;
  logic [7:0] upper_in_q;

  // Internal hits after boot never see the pins; boot reads always do
  assign internal_read_couple = cyc_int_q && !cyc_boot_q;
  assign external_read_couple = !internal_read_couple;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cpu_rdata <= 8'h00;
      cpu_rdata_valid <= 1'b0;
      upper_in_q <= 8'h00;
    end
    else
    begin
      cpu_rdata_valid <= cpu_take && cyc_rw_q && !cyc_idle_q && expanded;
      if (cpu_take && cyc_rw_q)
        cpu_rdata <= external_read_couple ? mux_in : peripheral_bus;
      if (cpu_take && mode_sel)
        upper_in_q <= upper_in;
    end
  end

  // ==========================================================
  // AXI4-Lite slave
  // One write and one read at a time; no data register of the
  // multiplexed port is reachable in these modes.
  logic aw_got_q;
  logic w_got_q;
  logic [3:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;

  assign s_axi_awready = !aw_got_q && !s_axi_bvalid;
  assign s_axi_wready = !w_got_q && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      aw_addr_q <= 4'h0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= muxbus_pkg::RESP_OKAY;
      upper_dir_q <= muxbus_pkg::UPPER_DIR_RESET;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_got_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_got_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (aw_got_q && w_got_q)
      begin
        aw_got_q <= 1'b0;
        w_got_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (aw_addr_q == muxbus_pkg::OFS_UPPER_DIR)
        begin
          s_axi_bresp <= muxbus_pkg::RESP_OKAY;
          if (w_strb_q[0])
            upper_dir_q <= w_data_q[7:0];
        end
        else if (aw_addr_q == muxbus_pkg::OFS_STATUS || aw_addr_q == muxbus_pkg::OFS_UPPER_IN)
          s_axi_bresp <= muxbus_pkg::RESP_OKAY;
        else
          s_axi_bresp <= muxbus_pkg::RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= muxbus_pkg::RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= muxbus_pkg::RESP_OKAY;
      s_axi_rdata <= 32'h0000_0000;
      unique case (s_axi_araddr)
        muxbus_pkg::OFS_STATUS:
        begin
          s_axi_rdata[muxbus_pkg::ST_MODE_LSB +: 3] <= mode_q;
          s_axi_rdata[muxbus_pkg::ST_BOOT_BIT] <= mode_test && boot_cnt_q != 2'h0;
          s_axi_rdata[muxbus_pkg::ST_EXP_BIT] <= expanded;
        end
        muxbus_pkg::OFS_UPPER_DIR: s_axi_rdata[7:0] <= upper_dir_q;
        muxbus_pkg::OFS_UPPER_IN: s_axi_rdata[7:0] <= upper_in_q;
        default: s_axi_rresp <= muxbus_pkg::RESP_SLVERR;
      endcase
    end
    else if (s_axi_rvalid && s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_strobe_e_low: assert property (e_clk |-> !addr_strobe)
    else $error("strobe high while E high");
  // Reset exit still shows the parked strobe with the port off
  a_addr_phase: assert property (addr_strobe && !cpu_take
    |-> mux_oe == 8'hff && mux_out == cyc_addr_q[7:0])
    else $error("low address not on port during strobe");
  a_gap_float: assert property (expanded && $rose(addr_strobe)
    |=> !e_clk && mux_oe == 8'h00)
    else $error("port driven in gap");
  a_port_off: assert property (!e_clk && !addr_strobe |-> mux_oe == 8'h00)
    else $error("port driven outside strobe and E");
  a_write_drive: assert property (e_clk && !direction_pin
    |-> mux_oe == 8'hff && mux_out == cyc_wdata_q)
    else $error("write data not driven in E");
  a_read_float: assert property (e_clk && direction_pin && !mode_test |-> mux_oe == 8'h00)
    else $error("port driven on read outside mode 0");
  a_test_int_drive: assert property (e_clk && mode_test && cyc_rw_q && cyc_int_q
    && !cyc_boot_q |-> mux_oe == 8'hff)
    else $error("mode 0 internal read not visible");
  a_rd_arbiter: assert property (cpu_take && cyc_rw_q && internal_read_couple
    |=> cpu_rdata == $past(peripheral_bus))
    else $error("internal read took external data");
  a_boot_ext: assert property (cpu_take && cyc_rw_q && cyc_boot_q
    |=> cpu_rdata == $past(mux_in))
    else $error("boot read not from pins");
  a_boot_float: assert property (e_clk && cyc_rw_q && cyc_boot_q |-> mux_oe == 8'h00)
    else $error("port driven during boot read");
  a_boot_ends: assert property (cpu_take && boot_cnt_q == 2'h0 |=> !cyc_boot_q)
    else $error("boot cycle after the first two");
  a_upper_fixed: assert property (mode_fixed && !cpu_take |=> upper_oe == 8'hff
    && upper_out == cyc_addr_q[15:8])
    else $error("upper address missing");
  a_upper_dir: assert property (mode_sel |=> upper_oe == $past(upper_dir_q))
    else $error("upper enable not per direction bits");
  a_idle_high: assert property (cyc_idle_q && expanded && !cpu_take |=> direction_pin
    && upper_out == 8'hff)
    else $error("idle cycle not a top read");
  // Own disable: the default one would mask this check entirely
  a_reset_pins: assert property (@(posedge aclk) disable iff (1'b0)
    !aresetn |=> direction_pin && addr_strobe && mux_oe == 8'h00 && upper_out == 8'hff)
    else $error("pins wrong in reset");

  c_write: cover property (e_clk && !direction_pin);
  c_test_int: cover property (e_clk && mode_test && mux_oe == 8'hff && direction_pin);
  c_boot_read: cover property (cpu_rdata_valid && mode_test && boot_cnt_q == 2'h0);
  c_dir_set: cover property (mode_sel && upper_oe != 8'h00);
  c_boot_fetch: cover property (cpu_take && cyc_boot_q && cyc_rw_q && !cyc_idle_q);

endmodule // muxed_expansion_bus_port
`default_nettype wire

// >>> dv/ext_mem_model.sv
`timescale 1ns/100ps
`default_nettype none
module ext_mem_model
(
  input wire logic aclk,
  input wire logic addr_strobe,
  input wire logic e_clk,
  input wire logic direction_pin,
  input wire logic quiet,
  input wire logic [7:0] pins,
  input wire logic [7:0] upper_pins,
  output logic [7:0] drive_d
);
  logic [7:0] lat_q;
  logic [7:0] float_q = 8'h00;
  logic [15:0] addr;
  // ==========
  // Address latch and responder
  always_ff @(posedge aclk)
  begin
    if (addr_strobe)
      lat_q <= pins;
    // Released bus must not keep its last value
    float_q <= ~float_q;
  end
  assign addr = {upper_pins, lat_q};
  // Vector decode is the same table, so boot fetches also answer
  assign drive_d = (e_clk && direction_pin && !quiet)
    ? (addr[7:0] ^ addr[15:8] ^ 8'h3c) : float_q;
endmodule // ext_mem_model
`default_nettype wire

// >>> dv/muxed_expansion_bus_port_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module muxed_expansion_bus_port_tb_top;
  typedef struct {logic [15:0] a; logic rw; logic idl; logic inr; logic [7:0] wd;
    logic [7:0] pb; logic [7:0] ex;} req_t;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [2:0] mode_straps = 3'h1;
  logic [15:0] cpu_addr = 16'hffff;
  logic cpu_rw = 1'b1;
  logic cpu_idle = 1'b1;
  logic cpu_internal = 1'b0;
  logic [7:0] cpu_wdata = 8'h00;
  logic [7:0] peripheral_bus = 8'h00;
  logic [3:0] s_axi_awaddr = 4'h0;
  logic [3:0] s_axi_araddr = 4'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic quiet = 1'b0;
  logic cpu_take, cpu_rdata_valid, e_clk, addr_strobe, direction_pin, m0, m6;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, v;
  logic [7:0] cpu_rdata, mux_out, mux_oe, mux_in, upper_out, upper_oe, upper_in, ext_d, dir;
  logic [2:0] mlist [5] = '{3'h1, 3'h2, 3'h3, 3'h6, 3'h0};
  int bad_count = 0;
  int checks = 0;
  int seed = 21349;
  int nw = 0;
  req_t p, q, pp, idle;
  // ==========
  // Pin levels
  assign mux_in = (mux_oe & mux_out) | (~mux_oe & ext_d);
  assign upper_in = (upper_oe & upper_out) | ~upper_oe;
  initial forever #50 aclk = ~aclk;
  muxed_expansion_bus_port i_dut (.*);
  ext_mem_model i_mem (.aclk, .addr_strobe, .e_clk, .direction_pin, .quiet, .pins(mux_in),
    .upper_pins(upper_in), .drive_d(ext_d));
  // ==========
  // Helpers
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic req_t mk(input logic [15:0] a, input logic [2:0] f, input logic [7:0] w,
    input logic [7:0] b);
    mk = '{a, f[2], f[1], f[0], w, b, 8'h00};
  endfunction
  function automatic logic [7:0] ext_byte(input logic [15:0] a);
    logic [7:0] hi;
    hi = m6 ? ((a[15:8] & dir) | ~dir) : a[15:8];
    return a[7:0] ^ hi ^ 8'h3c;
  endfunction
  task sync;
    do @(posedge aclk); while (cpu_take !== 1'b1);
    q = idle;
    p = idle;
    pp = idle;
  endtask
  task rst(input logic [2:0] m);
    m0 = (m == muxbus_pkg::MODE_TEST);
    m6 = (m == muxbus_pkg::MODE_SELECT);
    dir = 8'h00;
    mode_straps <= m;
    aresetn <= 1'b0;
    repeat (10) @(posedge aclk);
    #10;
    check({addr_strobe, direction_pin, mux_oe, upper_out}, {2'h3, 8'h00, 8'hff});
    check(upper_oe, (m <= muxbus_pkg::MODE_FIXED_MAX) ? 8'hff : 8'h00);
    @(posedge aclk);
    aresetn <= 1'b1;
    nw = 0;
    sync;
  endtask
  // Pipelined: sends n, walks the one taken now, checks read data of the one before
  task cyc(input req_t n);
    logic boot;
    logic [15:0] ea;
    logic [7:0] eoe;
    logic [7:0] uo;
    boot = m0 && (nw < 2);
    pp = p;
    p = q;
    q = n;
    cpu_addr <= n.a;
    cpu_rw <= n.rw;
    cpu_idle <= n.idl;
    cpu_internal <= n.inr;
    cpu_wdata <= n.wd;
    peripheral_bus <= p.pb;
    quiet <= m0 && p.inr && !boot;
    ea = p.idl ? 16'hffff : p.a;
    p.ex = (p.inr && !boot) ? p.pb : ext_byte(ea);
    eoe = (!p.idl && (!p.rw || (m0 && p.inr && !boot))) ? 8'hff : 8'h00;
    uo = m6 ? dir : 8'hff;
    #10;
    check(cpu_rdata_valid, pp.rw && !pp.idl);
    if (pp.rw && !pp.idl)
      check(cpu_rdata, pp.ex);
    check(addr_strobe & ~e_clk & ~cpu_take, 1'b1);
    check(mux_oe, 8'hff);
    check(mux_out, ea[7:0]);
    check(direction_pin, p.rw | p.idl);
    check(upper_oe, uo);
    check(upper_out & uo, ea[15:8] & uo);
    @(posedge aclk);
    #10;
    check({addr_strobe, e_clk, mux_oe}, 10'h0);
    repeat (2)
    begin
      @(posedge aclk);
      #10;
      check({e_clk, addr_strobe, mux_oe}, {2'h2, eoe});
      if (eoe[0])
        check(mux_out, p.rw ? p.pb : p.wd);
    end
    check(cpu_take, 1'b1);
    @(posedge aclk);
    nw++;
  endtask
  task axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1);
    check(s_axi_bresp, r);
    s_axi_bready <= 1'b0;
  endtask
  task axi_rd(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end
    while (s_axi_rvalid !== 1'b1);
    check({s_axi_rresp, s_axi_rdata}, {r, d});
    s_axi_rready <= 1'b0;
  endtask
  task final_report;
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // ==========
  // Sequence
  initial
  begin
    repeat (30000) @(posedge aclk);
    bad_count++;
    final_report;
  end
  initial
  begin
    idle = mk(16'hffff, 3'h6, 8'h00, 8'h00);
    foreach (mlist[i])
    begin
      rst(mlist[i]);
      cyc(mk(16'hfffe, 3'h5, 8'h00, 8'h11));
      cyc(mk(16'hffff, 3'h5, 8'h00, 8'h22));
      cyc(mk(16'h0100, 3'h0, 8'ha5, 8'h33));
      cyc(mk(16'h0080, 3'h1, 8'h5a, 8'h44));
      cyc(mk(16'h1234, 3'h2, 8'h00, 8'h00));
      cyc(mk(16'h0100, 3'h4, 8'h00, 8'h55));
      repeat (2) cyc(idle);
      axi_wr(muxbus_pkg::OFS_STATUS, 32'hffffffff, 4'hf, muxbus_pkg::RESP_OKAY);
      axi_rd(muxbus_pkg::OFS_STATUS, {27'h0, 2'h2, mlist[i]}, muxbus_pkg::RESP_OKAY);
      axi_wr(4'hc, 32'h1, 4'hf, muxbus_pkg::RESP_SLVERR);
      axi_rd(4'hc, 32'h0, muxbus_pkg::RESP_SLVERR);
      if (m6)
      begin
        axi_rd(muxbus_pkg::OFS_UPPER_DIR, 32'h0, muxbus_pkg::RESP_OKAY);
        axi_wr(muxbus_pkg::OFS_UPPER_DIR, 32'hff, 4'he, muxbus_pkg::RESP_OKAY);
        axi_rd(muxbus_pkg::OFS_UPPER_DIR, 32'h0, muxbus_pkg::RESP_OKAY);
        axi_wr(muxbus_pkg::OFS_UPPER_DIR, 32'h81, 4'hf, muxbus_pkg::RESP_OKAY);
        axi_rd(muxbus_pkg::OFS_UPPER_DIR, 32'h81, muxbus_pkg::RESP_OKAY);
        axi_rd(muxbus_pkg::OFS_UPPER_IN, 32'hff, muxbus_pkg::RESP_OKAY);
        dir = 8'h81;
      end
      sync;
      repeat (40)
      begin
        v = $random(seed);
        cyc(mk(v[15:0], {v[16], v[19:17] == 3'h0, v[28] && v[19:17] != 3'h0},
          v[27:20], v[31:24]));
      end
      repeat (2) cyc(idle);
    end
    // Strap outside the bus modes: strobe, port and upper lines stay off
    rst(3'h5);
    repeat (6) @(posedge aclk);
    #10;
    check({addr_strobe, direction_pin, mux_oe, upper_oe, cpu_rdata_valid}, {2'h1, 16'h0000, 1'h0});
    axi_rd(muxbus_pkg::OFS_STATUS, 32'h5, muxbus_pkg::RESP_OKAY);
    final_report;
  end
endmodule // muxed_expansion_bus_port_tb_top
`default_nettype wire
